/* File: core/rabsb_pkg.sv */
package rabsb_pkg;

   // ----------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] OFS_CAL_TIME = 8'h00;
   localparam logic [7:0] OFS_CAL_DATE = 8'h04;
   localparam logic [7:0] OFS_CONTROL = 8'h08;
   localparam logic [7:0] OFS_INIT_FLAGS = 8'h0C;
   localparam logic [7:0] OFS_PRESCALER = 8'h10;
   localparam logic [7:0] OFS_WAKEUP = 8'h14;
   localparam logic [7:0] OFS_COARSE_CAL = 8'h18;
   localparam logic [7:0] OFS_ALRB_SUBSEC = 8'h48;
   localparam logic [7:0] OFS_BKP_FIRST = 8'h50;
   localparam logic [7:0] OFS_BKP_LAST = 8'h9C;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'hA0;
   localparam logic [7:0] OFS_IRQ_MASK = 8'hA4;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int SS_W = 15;
   localparam int MASKCNT_LSB = 24;
   localparam int MASKCNT_W = 4;
   localparam int CR_ALRB_EN_BIT = 8;
   localparam int CR_ALRB_IRQ_EN_BIT = 13;
   localparam int ISR_INIT_MODE_BIT = 7;
   localparam int ISR_ALRB_FLAG_BIT = 9;
   localparam int IRQ_ALRB_BIT = 0;
   localparam int IRQ_TAMPER_BIT = 1;
   localparam int IRQ_W = 2;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [31:0] RST_CAL_TIME = 32'h0000_0000;
   localparam logic [31:0] RST_CAL_DATE = 32'h0000_2101;
   localparam logic [31:0] RST_CONTROL = 32'h0000_0000;
   localparam logic [31:0] RST_INIT_FLAGS = 32'h0000_0005;
   localparam logic [31:0] RST_PRESCALER = 32'h007F_00FF;
   localparam logic [31:0] RST_WAKEUP = 32'h0000_FFFF;
   localparam logic [31:0] RST_COARSE_CAL = 32'h0000_0000;
   localparam logic [31:0] RST_BKP_DOMAIN = 32'h0000_0000;

   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef struct packed {
      logic [15:0] ss_count;
      logic sec_tick;
      logic fields_match;
      logic tamper_flag;
   } rabsb_cal_in_t;

endpackage

/* File: core/rabsb_core.sv */
// Contract
// RL1: Mask count zero skips sub-second compare and alarm B fires on the seconds tick when other fields match.
// RL2: Mask count n of 1 to 14 compares only sub-second bits n-1..0 and ignores bits 14..n.
// RL3: Mask count fifteen needs all 15 stored sub-second bits equal to the counter.
// RL4: Counter bit 15, the overflow bit, never takes part in the alarm B compare.
// RL5: The stored 15-bit sub-second value is compared against the live prescaler counter.
// RL6: The 4-bit mask count sits in bits 27..24 of the sub-second register; other upper bits read zero.
// RL7: Software writes the sub-second register only with alarm B irq enable clear or in init mode.
// RL8: Twenty 32-bit backup words at 0x50..0x9C are freely readable and writable.
// RL9: Backup words survive system reset and low-power operation.
// RL10: Backup words are cleared on tamper and held cleared while the tamper flag stays set.
// RL11: Backup domain reset zeroes the sub-second register and the backup words; system reset does not.
// RL12: Mask counts 4 through 11 compare exactly that many low sub-second bits.
`timescale 1ns/1ps
`default_nettype none

module rabsb_core #(
   parameter int BKP_WORDS = 20
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic bkp_rst_n,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire rabsb_pkg::rabsb_cal_in_t cal_in,
   output logic alarm_b_pulse,
   output logic irq
);

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   function automatic logic [14:0] ss_cmp_mask(input logic [3:0] cnt);
      logic [14:0] m;
      m = '0;
      for (int i = 0; i < 15; i++)
      begin
         m[i] = (4'(i) < cnt);
      end
      return m;
   endfunction

   function automatic logic is_bkp(input logic [7:0] a);
      return (a >= rabsb_pkg::OFS_BKP_FIRST) && (a <= rabsb_pkg::OFS_BKP_LAST) && (a[1:0] == 2'b00);
   endfunction

   wire logic setup_ph = psel && !penable;
   wire logic access_ph = psel && penable && clk_en;
   wire logic wr_acc = access_ph && pwrite;
   wire logic [7:0] bkp_ofs = paddr - rabsb_pkg::OFS_BKP_FIRST;
   wire logic [4:0] bkp_idx = bkp_ofs[6:2];
   wire logic hit_cal = (paddr <= rabsb_pkg::OFS_COARSE_CAL) && (paddr[1:0] == 2'b00);
   wire logic hit_ss = (paddr == rabsb_pkg::OFS_ALRB_SUBSEC);
   wire logic hit_bkp = is_bkp(paddr);
   wire logic hit_ist = (paddr == rabsb_pkg::OFS_IRQ_STATUS);
   wire logic hit_imk = (paddr == rabsb_pkg::OFS_IRQ_MASK);
   wire logic hit_any = hit_cal || hit_ss || hit_bkp || hit_ist || hit_imk;

   assign pready = clk_en;

   // ----------------------------------------
   // Calendar and control storage
   // ----------------------------------------
   logic [31:0] cal_ff [7];
   localparam logic [31:0] CAL_RST [7] = '{rabsb_pkg::RST_CAL_TIME, rabsb_pkg::RST_CAL_DATE,
      rabsb_pkg::RST_CONTROL, rabsb_pkg::RST_INIT_FLAGS, rabsb_pkg::RST_PRESCALER,
      rabsb_pkg::RST_WAKEUP, rabsb_pkg::RST_COARSE_CAL};

   for (genvar g = 0; g < 7; g++)
   begin : g_cal
      always_ff @(posedge ref_clk)
      begin
         if (!rst_n)
            cal_ff[g] <= CAL_RST[g];
         else if (wr_acc && hit_cal && paddr[4:2] == 3'(g))
            cal_ff[g] <= pwdata;
      end
   end

   wire logic [31:0] ctrl = cal_ff[2];
   wire logic alrb_en = ctrl[rabsb_pkg::CR_ALRB_EN_BIT];
   wire logic alrb_irq_en = ctrl[rabsb_pkg::CR_ALRB_IRQ_EN_BIT];
   wire logic init_mode = cal_ff[3][rabsb_pkg::ISR_INIT_MODE_BIT];

   // ----------------------------------------
   // Alarm B sub-second register
   // ----------------------------------------
   logic [14:0] ssval_ff;
   logic [3:0] maskcnt_ff;
   // Writes while the alarm B interrupt is enabled would race the compare
   wire logic ss_wr_ok = !alrb_irq_en || init_mode; // [RL7]

   always_ff @(posedge ref_clk)
   begin
      if (!bkp_rst_n)
      begin
         ssval_ff <= '0; // [RL11]
         maskcnt_ff <= '0;
      end
      else if (wr_acc && hit_ss && ss_wr_ok)
      begin
         ssval_ff <= pwdata[14:0];
         maskcnt_ff <= pwdata[rabsb_pkg::MASKCNT_LSB +: rabsb_pkg::MASKCNT_W]; // [RL6]
      end
   end

   wire logic [31:0] ss_rd = {4'h0, maskcnt_ff, 9'h000, ssval_ff}; // [RL6]

   // ----------------------------------------
   // Alarm B match
   // ----------------------------------------
   // Bit 15 of the counter is left out by using only [14:0]
   wire logic [14:0] live_ss = cal_in.ss_count[14:0]; // [RL4] [RL5]
   wire logic [14:0] cmp_mask = ss_cmp_mask(maskcnt_ff); // [RL2] [RL3] [RL12]
   wire logic ss_equal = ((live_ss ^ ssval_ff) & cmp_mask) == 15'h0000; // [RL5]
   wire logic ss_cond = (maskcnt_ff == 4'h0) ? cal_in.sec_tick : ss_equal; // [RL1]
   wire logic alarm_cond = alrb_en && cal_in.fields_match && ss_cond;

   logic alarm_prev_ff;
   logic alarm_pulse_ff;
   // Edge detect so a held match raises one event only
   wire logic alarm_evt = alarm_cond && !alarm_prev_ff;

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         alarm_prev_ff <= 1'b0;
         alarm_pulse_ff <= 1'b0;
      end
      else if (clk_en)
      begin
         alarm_prev_ff <= alarm_cond;
         alarm_pulse_ff <= alarm_evt;
      end
   end

   assign alarm_b_pulse = alarm_pulse_ff;

   // ----------------------------------------
   // Backup words
   // ----------------------------------------
   logic [31:0] bkp_ff [BKP_WORDS];

   // Only the backup-domain reset, never system reset, resets these
   for (genvar g = 0; g < BKP_WORDS; g++)
   begin : g_bkp
      always_ff @(posedge ref_clk)
      begin
         if (!bkp_rst_n)
            bkp_ff[g] <= rabsb_pkg::RST_BKP_DOMAIN; // [RL11] [RL9]
         else if (clk_en)
         begin
            if (cal_in.tamper_flag)
               bkp_ff[g] <= '0; // [RL10]
            else if (wr_acc && hit_bkp && bkp_idx == 5'(g))
               bkp_ff[g] <= pwdata; // [RL8]
         end
      end
   end

   // ----------------------------------------
   // Interrupts
   // ----------------------------------------
   logic [1:0] ist_ff;
   logic [1:0] imk_ff;
   logic tamper_prev_ff;
   wire logic tamper_evt = cal_in.tamper_flag && !tamper_prev_ff;
   wire logic [1:0] ev_set = {tamper_evt, alarm_evt};
   wire logic [1:0] ev_clr = (wr_acc && hit_ist) ? pwdata[1:0] : 2'b00;
   // Set wins over a simultaneous write-one clear
   wire logic [1:0] nxt_ist = (ist_ff & ~ev_clr) | ev_set;

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         ist_ff <= '0;
         imk_ff <= '0;
         tamper_prev_ff <= 1'b0;
      end
      else if (clk_en)
      begin
         ist_ff <= nxt_ist;
         tamper_prev_ff <= cal_in.tamper_flag;
         if (wr_acc && hit_imk)
            imk_ff <= pwdata[1:0];
      end
   end

   assign irq = |(ist_ff & imk_ff);

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   wire logic [31:0] isr_rd = cal_ff[3] | (32'(ist_ff[rabsb_pkg::IRQ_ALRB_BIT]) << rabsb_pkg::ISR_ALRB_FLAG_BIT);
   wire logic [31:0] nxt_prdata = hit_cal ? ((paddr[4:2] == 3'd3) ? isr_rd : cal_ff[paddr[4:2]]) :
                                  hit_ss ? ss_rd :
                                  hit_bkp ? bkp_ff[bkp_idx] :
                                  hit_ist ? {30'h0, ist_ff} :
                                  hit_imk ? {30'h0, imk_ff} : 32'h0000_0000;

   logic [31:0] prdata_ff;
   logic err_ff;

   // Captured in setup so access needs no wait state
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         prdata_ff <= '0;
         err_ff <= 1'b0;
      end
      else if (clk_en && setup_ph)
      begin
         prdata_ff <= pwrite ? 32'h0000_0000 : nxt_prdata;
         err_ff <= !hit_any;
      end
   end

   assign prdata = prdata_ff;
   assign pslverr = err_ff && psel && penable;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_mask_zero_tick: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL1]
      (clk_en && alarm_evt && maskcnt_ff == 4'h0) |-> cal_in.sec_tick && cal_in.fields_match)
      else $error("alarm B fired with zero mask count but no seconds tick");

   a_low_bits_match: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL2]
      (clk_en && alarm_evt && maskcnt_ff != 4'h0)
      |-> ((live_ss ^ ssval_ff) & ((15'h0001 << maskcnt_ff) - 15'h0001)) == 15'h0000)
      else $error("alarm B fired with low sub-second bits unequal");

   a_full_compare: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL3]
      (clk_en && alarm_evt && maskcnt_ff == 4'hF) |-> cal_in.ss_count[14:0] == ssval_ff)
      else $error("alarm B fired with full mask and unequal value");

   a_ovf_ignored: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL4]
      (clk_en && alrb_en && cal_in.fields_match && maskcnt_ff != 4'h0 && !alarm_prev_ff
       && cal_in.ss_count[14:0] == ssval_ff) |=> alarm_b_pulse)
      else $error("alarm B missed on equal counter");

   a_upper_read_zero: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL6]
      (psel && penable && !pwrite && paddr == rabsb_pkg::OFS_ALRB_SUBSEC && $past(setup_ph) && $past(clk_en))
      |-> prdata[31:28] == 4'h0 && prdata[23:15] == 9'h000)
      else $error("reserved sub-second bits read nonzero");

   a_bkp_write_back: assert property (@(posedge ref_clk) disable iff (!bkp_rst_n) // [RL8]
      (wr_acc && paddr == rabsb_pkg::OFS_BKP_FIRST && !cal_in.tamper_flag) |=> bkp_ff[0] == $past(pwdata))
      else $error("backup word 0 did not take write data");

   a_bkp_sys_reset: assert property (@(posedge ref_clk) disable iff (!bkp_rst_n) // [RL9]
      (!rst_n && !psel && !cal_in.tamper_flag) |=> $stable(bkp_ff[BKP_WORDS - 1]))
      else $error("system reset disturbed a backup word");

   a_bkp_tamper_clr: assert property (@(posedge ref_clk) disable iff (!bkp_rst_n) // [RL10]
      (clk_en && cal_in.tamper_flag)[*2] |-> bkp_ff[0] == 32'h0000_0000 && bkp_ff[BKP_WORDS - 1] == 32'h0000_0000)
      else $error("backup words not cleared under tamper");

   a_bkp_dom_reset: assert property (@(posedge ref_clk) // [RL11]
      !bkp_rst_n |=> ssval_ff == 15'h0000 && maskcnt_ff == 4'h0 && bkp_ff[0] == 32'h0000_0000)
      else $error("backup domain reset left state nonzero");

   // ----------------------------------------
   // Checks: sub-second register and match
   // ----------------------------------------
   a_mask_zero_hold: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL1]
      (clk_en && maskcnt_ff == 4'h0 && !cal_in.sec_tick)
      |-> !alarm_evt)
      else $error("alarm B event with zero mask count and no seconds tick");

   a_mid_mask_compare: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL12]
      (clk_en && alarm_evt && maskcnt_ff >= 4'h4 && maskcnt_ff <= 4'hB)
      |-> ((live_ss ^ ssval_ff) & ((15'h0001 << maskcnt_ff) - 15'h0001)) == 15'h0000)
      else $error("alarm B fired with a middle mask count and unequal bits");

   a_ss_write_lock: assert property (@(posedge ref_clk) disable iff (!bkp_rst_n) // [RL7]
      (wr_acc && hit_ss && alrb_irq_en && !init_mode)
      |=> $stable(ssval_ff) && $stable(maskcnt_ff))
      else $error("locked sub-second register took a write");

   a_ss_write_take: assert property (@(posedge ref_clk) disable iff (!bkp_rst_n) // [RL6]
      (wr_acc && hit_ss && ss_wr_ok)
      |=> maskcnt_ff == $past(pwdata[rabsb_pkg::MASKCNT_LSB +: rabsb_pkg::MASKCNT_W]) && ssval_ff == $past(pwdata[14:0]))
      else $error("sub-second register did not take write data");

   a_ss_sys_reset: assert property (@(posedge ref_clk) disable iff (!bkp_rst_n) // [RL11]
      (!rst_n && !psel)
      |=> $stable(ssval_ff) && $stable(maskcnt_ff))
      else $error("system reset disturbed the sub-second register");

   a_pulse_one_cycle: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (clk_en && alarm_b_pulse)
      |=> !alarm_b_pulse)
      else $error("alarm B pulse lasted more than one cycle");

   // ----------------------------------------
   // Checks: bus, storage and interrupts
   // ----------------------------------------
   a_unmapped_err: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (psel && penable && $past(setup_ph) && $past(clk_en) && !hit_any)
      |-> pslverr)
      else $error("unmapped access gave no slave error");

   a_cal_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (wr_acc && hit_cal && paddr[4:2] == 3'd1)
      |=> cal_ff[1] == $past(pwdata))
      else $error("date register did not take write data");

   a_bkp_frozen: assert property (@(posedge ref_clk) disable iff (!bkp_rst_n)
      (!clk_en)
      |=> $stable(bkp_ff[0]))
      else $error("backup word changed with the clock disabled");

   a_alarm_status_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (clk_en && alarm_evt)
      |=> ist_ff[rabsb_pkg::IRQ_ALRB_BIT])
      else $error("alarm B event did not set its status bit");

   a_tamper_status_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (clk_en && tamper_evt)
      |=> ist_ff[rabsb_pkg::IRQ_TAMPER_BIT])
      else $error("tamper rise did not set its status bit");

   a_status_w1c: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (wr_acc && hit_ist && pwdata[rabsb_pkg::IRQ_ALRB_BIT] && !alarm_evt)
      |=> !ist_ff[rabsb_pkg::IRQ_ALRB_BIT])
      else $error("write of one did not clear alarm status");

   a_imask_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (wr_acc && hit_imk)
      |=> imk_ff == $past(pwdata[1:0]))
      else $error("interrupt mask did not take write data");

endmodule

`default_nettype wire

/* File: verification/rabsb_core_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module rabsb_core_tb_top;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic ref_clk, rst_n, bkp_rst_n, clk_en, psel, penable, pwrite, pready, pslverr, alarm_b_pulse, irq, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   rabsb_pkg::rabsb_cal_in_t cal;
   int bad_count = 0;
   int checks_done = 0;
   int cycles = 0;
   int pulses = 0;
   int base;
   localparam logic [14:0] SS_VAL = 15'h2AAA;

   rabsb_core uut (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .bkp_rst_n(bkp_rst_n),
      .clk_en(clk_en),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .cal_in(cal),
      .alarm_b_pulse(alarm_b_pulse),
      .irq(irq)
   );

   initial
   begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic finish_test;
      if (bad_count == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Entered just after a rising edge; leaves one idle cycle behind
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1)
         @(posedge ref_clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(name, rd, exp);
   endtask

   // Pulses counted here so a one-cycle alarm is never missed
   always @(posedge ref_clk)
   begin
      cycles <= cycles + 1;
      if (alarm_b_pulse === 1'b1)
         pulses <= pulses + 1;
      if (cycles == 20000)
      begin
         bad_count++;
         finish_test();
      end
   end

   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial
   begin
      rst_n = 1'b0;
      bkp_rst_n = 1'b0;
      clk_en = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      cal = '0;
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      bkp_rst_n <= 1'b1;
      @(posedge ref_clk);
      rdchk("subsec", 8'h48, 32'h0000_0000);
      rdchk("bkp19", 8'h9C, 32'h0000_0000);
      apb(1'b1, 8'h50, 32'hCAFE_0001);
      apb(1'b1, 8'h9C, 32'h1234_5678);
      apb(1'b1, 8'h04, 32'h0000_1234);
      // Reserved bits written high must read back low
      apb(1'b1, 8'h48, 32'hFF8F_AAAA);
      rdchk("subsec", 8'h48, 32'h0F00_2AAA);
      rdchk("bkp19", 8'h9C, 32'h1234_5678);
      rst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      rdchk("date", 8'h04, rabsb_pkg::RST_CAL_DATE);
      rdchk("bkp0", 8'h50, 32'hCAFE_0001);
      rdchk("subsec", 8'h48, 32'h0F00_2AAA);
      apb(1'b0, 8'h4C, 32'h0000_0000);
      chk("slverr", {31'h0000_0000, err}, 32'h0000_0001);
      apb(1'b1, 8'h08, 32'h0000_0100);
      for (int n = 1; n <= 15; n++)
      begin
         cal.fields_match <= 1'b0;
         apb(1'b1, 8'h48, {4'h0, n[3:0], 9'h000, SS_VAL});
         base = pulses;
         cal.ss_count <= {1'b0, SS_VAL ^ (15'h0001 << (n - 1))};
         cal.fields_match <= 1'b1;
         repeat (4) @(posedge ref_clk);
         chk("alarm low bit off", pulses - base, 32'h0000_0000);
         // Flip every ignored bit and the overflow bit
         cal.ss_count <= {1'b1, SS_VAL ^ ~((15'h0001 << n) - 15'h0001)};
         repeat (4) @(posedge ref_clk);
         chk("alarm match", pulses - base, 32'h0000_0001);
      end
      cal.fields_match <= 1'b0;
      apb(1'b1, 8'h48, 32'h0000_0000);
      base = pulses;
      cal.ss_count <= {1'b0, SS_VAL};
      cal.fields_match <= 1'b1;
      repeat (4) @(posedge ref_clk);
      chk("alarm no tick", pulses - base, 32'h0000_0000);
      cal.sec_tick <= 1'b1;
      @(posedge ref_clk);
      cal.sec_tick <= 1'b0;
      repeat (3) @(posedge ref_clk);
      chk("alarm tick", pulses - base, 32'h0000_0001);
      chk("irq masked", {31'h0000_0000, irq}, 32'h0000_0000);
      apb(1'b1, 8'hA4, 32'h0000_0001);
      chk("irq", {31'h0000_0000, irq}, 32'h0000_0001);
      apb(1'b1, 8'hA0, 32'h0000_0001);
      chk("irq clear", {31'h0000_0000, irq}, 32'h0000_0000);
      apb(1'b1, 8'h08, 32'h0000_2100);
      apb(1'b1, 8'h48, 32'h0300_0011);
      rdchk("subsec locked", 8'h48, 32'h0000_0000);
      apb(1'b1, 8'h0C, 32'h0000_0080);
      apb(1'b1, 8'h48, 32'h0300_0011);
      rdchk("subsec init", 8'h48, 32'h0300_0011);
      cal.tamper_flag <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rdchk("bkp0 tamper", 8'h50, 32'h0000_0000);
      apb(1'b1, 8'h50, 32'hFFFF_FFFF);
      rdchk("bkp0 held", 8'h50, 32'h0000_0000);
      rdchk("status", 8'hA0, 32'h0000_0002);
      cal.tamper_flag <= 1'b0;
      apb(1'b1, 8'h50, 32'h0000_0005);
      rdchk("bkp0", 8'h50, 32'h0000_0005);
      // Frozen clock must hide a tamper pulse from the backup words
      clk_en <= 1'b0;
      cal.tamper_flag <= 1'b1;
      repeat (3) @(posedge ref_clk);
      cal.tamper_flag <= 1'b0;
      clk_en <= 1'b1;
      @(posedge ref_clk);
      rdchk("bkp0 frozen", 8'h50, 32'h0000_0005);
      bkp_rst_n <= 1'b0;
      @(posedge ref_clk);
      bkp_rst_n <= 1'b1;
      @(posedge ref_clk);
      rdchk("bkp0 domain", 8'h50, 32'h0000_0000);
      rdchk("subsec domain", 8'h48, 32'h0000_0000);
      finish_test();
   end
endmodule

`default_nettype wire
